// ---- design/tqd_top.sv ----
// Top level of the three-axis quadrature decoder with its register file.
`timescale 1ns/1ns
`default_nettype none
module tqd_top #(
   parameter int PINS = 16
) (
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   input  wire logic [PINS-1:0]  gpio_i,
   input  wire logic             low_power_clock_i,
   input  wire logic [7:0]       addr_i,
   input  wire logic [31:0]      wdata_i,
   input  wire logic             wr_i,
   input  wire logic             rd_i,
   output logic      [31:0]      rdata_o,
   output logic                  irq_o
);
   localparam int AX = tqd_pkg::AXES;

   logic [7:0]                   irq_edge_threshold;
   logic [AX-1:0]                axis_enable;
   logic [15:0]                  channel_mode_select_reg;
   logic [tqd_pkg::DIV_W-1:0]    sample_clock_divider;
   logic [tqd_pkg::DIV_W-1:0]    div_cnt;
   logic                         sample;
   logic [tqd_pkg::STEP_W-1:0]   step_count [AX];
   logic [tqd_pkg::EDGE_W-1:0]   overall_edge_counter;
   logic                         irq_pending_flag;
   logic                         irq_mask;
   logic [AX-1:0]                any_edge;
   logic                         edge_counter_clear;
   logic                         thr_hit;
   logic [31:0]                  next_rdata;
   logic [tqd_pkg::DIV_W-1:0]    div_eff;
   logic                         irq_clear;
   logic                         next_irq_pending;
   logic                         next_irq_mask;

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_edge_threshold      <= tqd_pkg::THR_RST;
         axis_enable             <= '0;
         channel_mode_select_reg <= '0;
         sample_clock_divider    <= tqd_pkg::DIV_RST;
         irq_mask                <= 1'b0;
      end else if (wr_i) begin
         unique case (addr_i)
            tqd_pkg::ADDR_CTRL: begin
               irq_edge_threshold <= wdata_i[tqd_pkg::CTRL_THR_LSB +: 8];
               axis_enable        <= wdata_i[tqd_pkg::CTRL_EN_LSB +: AX];
            end
            tqd_pkg::ADDR_MODE_SEL: channel_mode_select_reg <= wdata_i[15:0];
            tqd_pkg::ADDR_DIV:      sample_clock_divider <= wdata_i[tqd_pkg::DIV_W-1:0];
            tqd_pkg::ADDR_IRQ_MASK: irq_mask <= wdata_i[tqd_pkg::STAT_THR];
            default: ;
         endcase
      end
   end

   assign edge_counter_clear = wr_i && (addr_i == tqd_pkg::ADDR_CMD)
                               && wdata_i[tqd_pkg::CMD_EDGE_CLR];

   // ----------------------------------------------------------------
   // Sample strobe
   // ----------------------------------------------------------------
   // Values below the 16 MHz floor are raised so the sample rate never exceeds it, except while low_power_clock_i forces a sample every cycle.
   assign div_eff = (sample_clock_divider < tqd_pkg::DIV_W'(tqd_pkg::MIN_DIV))
                    ? tqd_pkg::DIV_W'(tqd_pkg::MIN_DIV) : sample_clock_divider;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_cnt <= '0;
         sample  <= 1'b0;
      end else if (low_power_clock_i) begin
         div_cnt <= '0;
         sample  <= 1'b1;
      end else if (div_cnt >= div_eff - tqd_pkg::DIV_W'(1)) begin
         div_cnt <= '0;
         sample  <= 1'b1;
      end else begin
         div_cnt <= div_cnt + tqd_pkg::DIV_W'(1);
         sample  <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Per-axis decoders and step counters
   // ----------------------------------------------------------------
   for (genvar g = 0; g < AX; g++) begin : g_axis
      tqd_axis_if ax ();
      logic [tqd_pkg::SEL_W-1:0] pin_sel;
      // Selector picks pin pair (2n, 2n+1); pairs beyond the pins read low.
      assign pin_sel      = channel_mode_select_reg[g*tqd_pkg::SEL_W +: tqd_pkg::SEL_W];
      assign ax.sample    = sample;
      assign ax.chan_a    = (2*pin_sel < PINS) ? gpio_i[2*pin_sel] : 1'b0;
      assign ax.chan_b    = (2*pin_sel + 1 < PINS) ? gpio_i[2*pin_sel + 1] : 1'b0;
      assign ax.enable    = axis_enable[g];
      assign ax.edge_mode = channel_mode_select_reg[tqd_pkg::SEL_MODE_LSB + g];
      assign any_edge[g]  = ax.any_edge;

      tqd_axis_dec u_dec (
         .clk_i  (clk_i),
         .nrst_i (nrst_i),
         .ax     (ax)
      );

      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            step_count[g] <= '0;
         end else if (!axis_enable[g]) begin
            step_count[g] <= '0;
         end else if (ax.step_up) begin
            step_count[g] <= step_count[g] + tqd_pkg::STEP_W'(1);
         end else if (ax.step_down) begin
            step_count[g] <= step_count[g] - tqd_pkg::STEP_W'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // Overall edge counter and interrupt
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         overall_edge_counter <= '0;
      end else if (edge_counter_clear) begin
         overall_edge_counter <= '0;
      end else if (|any_edge) begin
         overall_edge_counter <= overall_edge_counter + tqd_pkg::EDGE_W'(1);
      end
   end

   // Match on the step into the threshold so the flag rises once per crossing.
   assign thr_hit = (|any_edge) && !edge_counter_clear
                    && (overall_edge_counter + tqd_pkg::EDGE_W'(1) == irq_edge_threshold);

   assign irq_clear = wr_i && (addr_i == tqd_pkg::ADDR_IRQ_STAT)
                      && wdata_i[tqd_pkg::STAT_THR];

   // A crossing in the same cycle as a clear wins, so no threshold event is lost.
   assign next_irq_pending = thr_hit || (irq_pending_flag && !irq_clear);
   assign next_irq_mask    = (wr_i && (addr_i == tqd_pkg::ADDR_IRQ_MASK))
                             ? wdata_i[tqd_pkg::STAT_THR] : irq_mask;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_pending_flag <= 1'b0;
      end else if (thr_hit) begin
         irq_pending_flag <= 1'b1;
      end else if (irq_clear) begin
         irq_pending_flag <= 1'b0;
      end
   end

   // Built from the next flag and mask so the pin always equals flag and mask of its cycle.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) irq_o <= 1'b0;
      else irq_o <= next_irq_pending && next_irq_mask;
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = '0;
      unique case (addr_i)
         tqd_pkg::ADDR_CTRL: begin
            next_rdata[tqd_pkg::CTRL_THR_LSB +: 8] = irq_edge_threshold;
            next_rdata[tqd_pkg::CTRL_EN_LSB +: AX] = axis_enable;
         end
         tqd_pkg::ADDR_MODE_SEL: next_rdata[15:0] = channel_mode_select_reg;
         tqd_pkg::ADDR_DIV:      next_rdata[tqd_pkg::DIV_W-1:0] = sample_clock_divider;
         tqd_pkg::ADDR_X_CNT:    next_rdata = {{16{step_count[0][15]}}, step_count[0]};
         tqd_pkg::ADDR_Y_CNT:    next_rdata = {{16{step_count[1][15]}}, step_count[1]};
         tqd_pkg::ADDR_Z_CNT:    next_rdata = {{16{step_count[2][15]}}, step_count[2]};
         tqd_pkg::ADDR_EDGE_CNT: next_rdata[tqd_pkg::EDGE_W-1:0] = overall_edge_counter;
         tqd_pkg::ADDR_IRQ_STAT: next_rdata[tqd_pkg::STAT_THR] = irq_pending_flag;
         tqd_pkg::ADDR_IRQ_MASK: next_rdata[tqd_pkg::STAT_THR] = irq_mask;
         default:                next_rdata = '0;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) rdata_o <= '0;
      else if (rd_i) rdata_o <= next_rdata;
      else rdata_o <= '0;
   end
endmodule
`default_nettype wire

// ---- design/tqd_pkg.sv ----
// Package of constants and types for the three-axis quadrature decoder.
package tqd_pkg;
   // ----------------------------------------------------------------
   // Register map (byte offsets on the plain register port)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_MODE_SEL = 8'h04;
   localparam logic [7:0] ADDR_DIV      = 8'h08;
   localparam logic [7:0] ADDR_X_CNT    = 8'h0C;
   localparam logic [7:0] ADDR_Y_CNT    = 8'h10;
   localparam logic [7:0] ADDR_Z_CNT    = 8'h14;
   localparam logic [7:0] ADDR_EDGE_CNT = 8'h18;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
   localparam logic [7:0] ADDR_CMD      = 8'h24;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int CTRL_THR_LSB   = 0;
   localparam int CTRL_EN_LSB    = 8;
   localparam int SEL_W          = 4;
   localparam int SEL_Y_LSB      = 4;
   localparam int SEL_Z_LSB      = 8;
   localparam int SEL_MODE_LSB   = 12;
   localparam int CMD_EDGE_CLR   = 0;
   localparam int STAT_THR       = 0;

   // ----------------------------------------------------------------
   // Widths, reset values and timing
   // ----------------------------------------------------------------
   localparam int AXES           = 3;
   localparam int STEP_W         = 16;
   localparam int EDGE_W         = 8;
   localparam int DIV_W          = 10;
   localparam int FILT_LEN       = 3;
   localparam logic [7:0] THR_RST     = 8'h00;
   localparam logic [9:0] DIV_RST     = 10'h008;
   localparam int    CLK_HZ           = 125000000;
   localparam int    SAMPLE_MAX_HZ    = 16000000;
   localparam int    MIN_DIV          = (CLK_HZ + SAMPLE_MAX_HZ - 1) / SAMPLE_MAX_HZ;

   typedef enum logic {
      TQD_MODE_QUAD,
      TQD_MODE_EDGE
   } tqd_mode_e;
endpackage

// ---- design/tqd_axis_if.sv ----
// Interface carrying one axis worth of sample strobe, pins and decoder result.
`timescale 1ns/1ns
`default_nettype none
interface tqd_axis_if;
   logic       sample;
   logic       chan_a;
   logic       chan_b;
   logic       enable;
   logic       edge_mode;
   logic       step_up;
   logic       step_down;
   logic       any_edge;
   modport ctrl (output sample, chan_a, chan_b, enable, edge_mode, input step_up, step_down,
                 any_edge);
   modport dec  (input sample, chan_a, chan_b, enable, edge_mode, output step_up, step_down,
                 any_edge);
endinterface
`default_nettype wire

// ---- design/tqd_axis_dec.sv ----
// Filter, edge detector and quadrature step decoder for one axis.
`timescale 1ns/1ns
`default_nettype none
module tqd_axis_dec (
   input  wire logic  clk_i,
   input  wire logic  nrst_i,
   tqd_axis_if.dec    ax
);
   logic [tqd_pkg::FILT_LEN-1:0] hist_a;
   logic [tqd_pkg::FILT_LEN-1:0] hist_b;
   logic                         filt_a;
   logic                         filt_b;
   logic                         prev_a;
   logic                         prev_b;
   logic                         ch_a;
   logic                         ch_b;

   // A level is accepted only after it is seen on three samples in a row.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hist_a <= '0;
         hist_b <= '0;
         filt_a <= 1'b0;
         filt_b <= 1'b0;
      end else if (ax.sample) begin
         hist_a <= {hist_a[tqd_pkg::FILT_LEN-2:0], ax.chan_a};
         hist_b <= {hist_b[tqd_pkg::FILT_LEN-2:0], ax.chan_b};
         if (&hist_a) filt_a <= 1'b1;
         else if (~|hist_a) filt_a <= 1'b0;
         if (&hist_b) filt_b <= 1'b1;
         else if (~|hist_b) filt_b <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prev_a <= 1'b0;
         prev_b <= 1'b0;
      end else begin
         prev_a <= filt_a;
         prev_b <= filt_b;
      end
   end

   assign ch_a = filt_a ^ prev_a;
   assign ch_b = filt_b ^ prev_b;

   always_comb begin
      // Both channels changing together is one event; it has no direction in quadrature mode and counts up in edge mode.
      ax.any_edge  = ax.enable && (ch_a || ch_b);
      ax.step_up   = 1'b0;
      ax.step_down = 1'b0;
      if (ax.enable && ax.edge_mode) begin
         ax.step_up = ch_a || ch_b;
      end else if (ax.enable && (ch_a ^ ch_b)) begin
         // A leads: after an A change, A differs from B; after a B change, they match.
         if (ch_a) ax.step_up = filt_a ^ filt_b;
         else ax.step_up = ~(filt_a ^ filt_b);
         ax.step_down = ~ax.step_up;
      end
   end
endmodule
`default_nettype wire

// ---- dv/tqd_enc_model.sv ----
// Behavioural quadrature encoder standing on the sensor side of one axis.
`timescale 1ns/1ns
`default_nettype none
module tqd_enc_model (
   input  wire logic clk_i,
   input  wire logic step_i,
   input  wire logic back_i,
   output logic      a_o,
   output logic      b_o
);
   logic [1:0] ph = 2'h0;
   // Gray order 00,10,11,01 lets channel A lead on forward motion.
   always @(posedge clk_i) if (step_i) ph <= back_i ? ph - 2'h1 : ph + 2'h1;
   assign a_o = ph[0] ^ ph[1];
   assign b_o = ph[1];
endmodule
`default_nettype wire

// ---- dv/tqd_top_properties.sv ----
// Concurrent checks on the decoder's top-level ports.
`timescale 1ns/1ns
`default_nettype none
module tqd_top_chk #(
   parameter int PINS = 16
) (
   input  wire logic            clk_i,
   input  wire logic            nrst_i,
   input  wire logic [PINS-1:0] gpio_i,
   input  wire logic            low_power_clock_i,
   input  wire logic [7:0]      addr_i,
   input  wire logic [31:0]     wdata_i,
   input  wire logic            wr_i,
   input  wire logic            rd_i,
   input  wire logic [31:0]     rdata_o,
   input  wire logic            irq_o
);
   logic [10:0] ctrl_sh;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) ctrl_sh <= 11'h000;
      else if (wr_i && addr_i == tqd_pkg::ADDR_CTRL) ctrl_sh <= wdata_i[10:0];
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   chk_read_idle: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data not zero when idle");
   chk_unmapped_read: assert property (rd_i && addr_i == 8'h28 |=> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   chk_x_sign: assert property (rd_i && addr_i == tqd_pkg::ADDR_X_CNT |=>
      rdata_o[31:16] == {16{rdata_o[15]}}) else $error("step count not sign extended");
   chk_edge_width: assert property (rd_i && addr_i == tqd_pkg::ADDR_EDGE_CNT |=>
      rdata_o[31:8] == 24'h0) else $error("edge count wider than 8 bits");
   chk_irq_hold: assert property (irq_o && !wr_i |=> irq_o)
      else $error("interrupt dropped without a write");
   chk_stat_read: assert property (rd_i && addr_i == tqd_pkg::ADDR_IRQ_STAT && irq_o |=>
      rdata_o[0]) else $error("status reads clear while interrupt high");
   chk_mask_gate: assert property (wr_i && addr_i == tqd_pkg::ADDR_IRQ_MASK && !wdata_i[0]
      |=> (!wr_i |=> !irq_o)) else $error("masked interrupt still high");
   chk_ctrl_rdbk: assert property (rd_i && addr_i == tqd_pkg::ADDR_CTRL |=>
      rdata_o == {21'h0, ctrl_sh}) else $error("control readback differs");
endmodule
bind tqd_top tqd_top_chk #(.PINS(PINS)) u_tqd_top_chk (.clk_i(clk_i), .nrst_i(nrst_i),
   .gpio_i(gpio_i), .low_power_clock_i(low_power_clock_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
`default_nettype wire

// ---- dv/tqd_test.sv ----
// Self-checking testbench of the three-axis quadrature decoder.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin miscompares++; \
   $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module tqd_test;
   logic        clk_i = 1'b0, nrst_i = 1'b0, lp = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic        stp = 1'b0, bk = 1'b0, ya = 1'b0, yb = 1'b0, irq_o, ea, eb;
   logic [7:0]  addr_i = 8'h00;
   logic [11:0] hi = 12'h000;
   logic [31:0] wdata_i = 32'h0, rdata_o, rs = 32'hF6F19B16;
   int          miscompares = 0, n_checks = 0, n1, n2, m;
   always #4 clk_i = ~clk_i;
   tqd_enc_model u_tqd_enc_model (.clk_i(clk_i), .step_i(stp), .back_i(bk), .a_o(ea), .b_o(eb));
   tqd_top u_tqd_top (.clk_i(clk_i), .nrst_i(nrst_i), .gpio_i({hi, yb, ya, eb, ea}),
      .low_power_clock_i(lp), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] sx(input int v);
      logic [15:0] t;
      t = 16'(v);
      return {{16{t[15]}}, t};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      `CHK(nm, e, rdata_o)
   endtask
   // Pins above Y's pair, Z's selected pair included, get fresh random levels on every step.
   task automatic mv(input int n, input logic b, input int h);
      repeat (n) begin
         @(posedge clk_i);
         stp <= 1'b1;
         bk <= b;
         rs = lfsr(rs);
         hi <= rs[11:0];
         @(posedge clk_i);
         stp <= 1'b0;
         repeat (h) @(posedge clk_i);
      end
   endtask
   task automatic tg(input logic [1:0] t, input int h);
      @(posedge clk_i);
      {yb, ya} <= {yb, ya} ^ t;
      repeat (h) @(posedge clk_i);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      rchk(tqd_pkg::ADDR_CTRL, 32'h0, "ctrl");
      rchk(tqd_pkg::ADDR_DIV, {22'h0, tqd_pkg::DIV_RST}, "div");
      rchk(tqd_pkg::ADDR_X_CNT, 32'h0, "x reset");
      rchk(8'h28, 32'h0, "unmapped");
      $display("test reset done");
      rs = lfsr(rs);
      n1 = 1 + int'(rs[3:0]);
      n2 = 1 + int'(rs[5:4]);
      m = 2 + int'(rs[7:6]);
      // X on pair 0, Y on pair 1 in edge mode, Z on pair 2 and left disabled.
      wr(tqd_pkg::ADDR_MODE_SEL, 32'h2210);
      wr(tqd_pkg::ADDR_IRQ_MASK, 32'h1);
      wr(tqd_pkg::ADDR_CTRL, 32'h300 | 32'(n1 + n2));
      mv(n1, 1'b0, 40);
      mv(n2, 1'b1, 40);
      repeat (m) tg(2'b01, 40);
      tg(2'b10, 0);
      tg(2'b10, 40);
      tg(2'b11, 40);
      rchk(tqd_pkg::ADDR_X_CNT, sx(n1 - n2), "x steps");
      rchk(tqd_pkg::ADDR_Y_CNT, 32'(m + 1), "y edges");
      rchk(tqd_pkg::ADDR_Z_CNT, 32'h0, "z off");
      rchk(tqd_pkg::ADDR_EDGE_CNT, 32'(n1 + n2 + m + 1), "edges");
      `CHK("irq", 1'b1, irq_o)
      wr(tqd_pkg::ADDR_IRQ_MASK, 32'h0);
      @(negedge clk_i);
      `CHK("irq masked", 1'b0, irq_o)
      wr(tqd_pkg::ADDR_IRQ_MASK, 32'h1);
      @(negedge clk_i);
      `CHK("irq unmasked", 1'b1, irq_o)
      rchk(tqd_pkg::ADDR_IRQ_STAT, 32'h1, "stat set");
      $display("test motion done");
      wr(tqd_pkg::ADDR_IRQ_STAT, 32'h1);
      wr(tqd_pkg::ADDR_CMD, 32'h1);
      rchk(tqd_pkg::ADDR_IRQ_STAT, 32'h0, "stat");
      rchk(tqd_pkg::ADDR_EDGE_CNT, 32'h0, "edge clr");
      `CHK("irq clr", 1'b0, irq_o)
      wr(tqd_pkg::ADDR_CTRL, 32'h0);
      rchk(tqd_pkg::ADDR_X_CNT, 32'h0, "x off");
      rchk(tqd_pkg::ADDR_Y_CNT, 32'h0, "y off");
      $display("test clear done");
      wr(tqd_pkg::ADDR_DIV, 32'h3FF);
      rchk(tqd_pkg::ADDR_DIV, 32'h3FF, "div wr");
      // Steps too short for the divided rate only count with the bypass.
      @(posedge clk_i);
      lp <= 1'b1;
      wr(tqd_pkg::ADDR_CTRL, 32'h100);
      mv(5, 1'b1, 8);
      rchk(tqd_pkg::ADDR_X_CNT, sx(-5), "x bypass");
      $display("test bypass done");
      final_report;
   end
   initial begin
      #200000;
      miscompares++;
      final_report;
   end
endmodule
`default_nettype wire
